// file: common/msr_pkg.sv
// Shared constants and types for the master/slave role resolution block
package msr_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] MSR_OFS_CTRL    = 8'h00;
  localparam logic [7:0] MSR_OFS_STATUS  = 8'h04;
  localparam logic [7:0] MSR_OFS_SEED    = 8'h08;
  localparam logic [7:0] MSR_OFS_PARTNER = 8'h0c;
  localparam logic [7:0] MSR_OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0] MSR_OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] MSR_OFS_IRQ_EN  = 8'h18;

  // Control register field positions (local page 1 bits)
  localparam int MSR_CTRL_MAN_EN  = 0;
  localparam int MSR_CTRL_MAN_VAL = 1;
  localparam int MSR_CTRL_MULTI   = 2;

  // Status and partner register field positions
  localparam int MSR_ST_FAULT    = 15;
  localparam int MSR_ST_MASTER   = 14;
  localparam int MSR_ST_RESOLVED = 8;
  localparam int MSR_PARTNER_P1  = 16;

  // Interrupt event bit positions
  localparam int MSR_EV_OK    = 0;
  localparam int MSR_EV_FAULT = 1;
  localparam int MSR_EV_TIE   = 2;

  // Reset values
  localparam logic [2:0]  MSR_CTRL_RST = 3'h0;
  localparam logic [2:0]  MSR_IRQ_RST  = 3'h0;
  localparam logic [10:0] MSR_LFSR_RST = 11'h001;
  localparam logic [10:0] MSR_SEED_RST = 11'h000;

  // Seed handling
  localparam int          MSR_SEED_W    = 11;
  localparam logic [3:0]  MSR_MAX_SEEDS = 4'h7;
  localparam logic [10:0] MSR_SEED_MAX  = 11'h7fe;

  // End classification from page 1 bits
  typedef enum logic [1:0] {
    MSR_MANUAL_MASTER,
    MSR_MANUAL_SLAVE,
    MSR_MULTIPORT,
    MSR_SINGLEPORT
  } msr_type_t;

  // Result of one resolution step
  typedef enum logic [1:0] {
    MSR_RES_MASTER,
    MSR_RES_SLAVE,
    MSR_RES_TIE,
    MSR_RES_FAULT
  } msr_res_t;

endpackage : msr_pkg

// file: common/msr_seed_if.sv
// Request and answer path between resolver and seed generator
`timescale 1ns/100ps
`default_nettype none
interface msr_seed_if;
  logic        req;    // Resolver asks for a fresh seed
  logic        valid;  // One-cycle pulse, seed is fresh
  logic [10:0] seed;   // Seed value, 0 up to 2046

  modport gen  (input req, output valid, output seed);
  modport user (output req, input valid, input seed);
endinterface : msr_seed_if
`default_nettype wire

// file: src/msr_seed_gen.sv
// Pseudo-random seed generator for role tie-breaking
`timescale 1ns/100ps
`default_nettype none
module msr_seed_gen import msr_pkg::*; (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  // Seed path
  msr_seed_if.gen  seedIf
);

  logic [10:0] lfsr_reg;   // Free-running state, never zero
  logic [10:0] lfsr_next;  // Shifted state
  logic [10:0] seed_reg;   // Captured seed
  logic        valid_reg;  // Answer pulse

  // Shift stages, one per bit above bit 0
  genvar i;
  generate
    for (i = 1; i < MSR_SEED_W; i++) begin : g_shift
      assign lfsr_next[i] = lfsr_reg[i-1];
    end
  endgenerate
  // Feedback taps give a maximal 2047-state cycle
  assign lfsr_next[0] = lfsr_reg[8] ^ lfsr_reg[10];

  // Free run: request timing adds entropy between two ends
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lfsr_reg <= MSR_LFSR_RST;
    end else if (clkEn) begin
      lfsr_reg <= lfsr_next;
    end
  end

  // Capture on request; state minus one spans 0..2046 evenly
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seed_reg  <= MSR_SEED_RST;
      valid_reg <= 1'b0;
    end else if (clkEn) begin
      valid_reg <= seedIf.req && !valid_reg;
      if (seedIf.req && !valid_reg) begin
        seed_reg <= lfsr_reg - 11'h001;
      end
    end
  end

  assign seedIf.seed  = seed_reg;
  assign seedIf.valid = valid_reg;

  // Seed never reaches the all-ones value
  property p_seed_range;
    @(posedge ref_clk) disable iff (reset)
      valid_reg |-> seed_reg <= MSR_SEED_MAX;
  endproperty
  a_seed_range: assert property (p_seed_range) else $error("Seed out of range");

endmodule : msr_seed_gen
`default_nettype wire

// file: src/msr_resolver.sv
// Master/slave role resolution with Avalon-MM register access
// Behaviour
// - Evaluate once on entering link-good check
// - Classify ends from page-1 bits U0..U2
// - Multiport beats single-port when neither manual
// - Manual master/slave wins against non-conflicting partner
// - Same type: higher 11-bit seed is master
// - Equal seeds force link fail, retry
// - Seeds uniform over 0 to 2046
// - Seed counter cleared at start, counts seeds
// - Completion with gigabit HCD clears seed counter; success also clears fault bit
// - Fault after seven seeds without resolution
// - Both manual same role sets fault bit
// - Fault completes resolution, forces link fail
// - Success sets role bit, reports role
// - Arbitrate only when gigabit copper is HCD
// - Tie with manual off: new seed, relink
// - Manual value ignored when manual disabled
// - Seed carried in page 2, U10 MSB
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module msr_resolver import msr_pkg::*; (
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  // Avalon-MM slave
  input  wire logic [7:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic      [31:0] avsReadData,
  output logic             avsWaitRequest,
  // Auto-negotiation side
  input  wire logic        agEnter,
  input  wire logic        hcdIsGigT,
  input  wire logic [2:0]  remotePage1,
  input  wire logic [10:0] remoteSeed,
  output logic      [2:0]  localPage1,
  output logic      [10:0] localSeed,
  output logic             linkFail,
  output logic             resolveDone,
  // PMA configuration side
  output logic             roleMaster,
  output logic             roleInd,
  output logic             cfgFault,
  // Interrupt
  output logic             irq
);

  // Resolution sequencer states
  typedef enum logic [1:0] {ST_RESEED, ST_IDLE, ST_RESOLVE} msr_state_t;

  msr_state_t  state_reg;       // Sequencer state
  logic [2:0]  ctrl_reg;        // Local page 1 bits
  logic [2:0]  remP1_reg;       // Latched partner page 1
  logic [10:0] remSeed_reg;     // Latched partner seed
  logic        hcd_reg;         // Latched HCD flag
  logic [10:0] seed_reg;        // Current local seed
  logic [3:0]  seedCnt_reg;     // Seeds since last arbitrated completion
  logic        master_reg;      // Resolved role
  logic        fault_reg;       // Configuration fault
  logic        resolved_reg;    // A role has been resolved
  logic        linkFail_reg;    // Link fail pulse
  logic        done_reg;        // Completion pulse
  logic        ind_reg;         // Role indication pulse
  logic [2:0]  irqSt_reg;       // Sticky events
  logic [2:0]  irqEn_reg;       // Event enables
  logic        irq_reg;         // Interrupt line
  logic [31:0] rdata_reg;       // Read data
  logic        wait_reg;        // Wait request
  logic [2:0]  events;          // Events this cycle
  msr_type_t   localType;       // Local classification
  msr_type_t   remoteType;      // Partner classification
  msr_res_t    outcome;         // Resolution outcome
  logic        busAcc;          // Bus access completes
  logic        seedLimit;       // Seventh seed already used

  msr_seed_if seedIf ();        // Link to the seed generator

  // Seed generator
  msr_seed_gen u_seed (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clkEn   (clkEn),
    .seedIf  (seedIf.gen)
  );

  // Classify an end; value bit only counts when manual is on
  function automatic msr_type_t classify(input logic [2:0] p1);
    if (p1[MSR_CTRL_MAN_EN]) begin
      classify = p1[MSR_CTRL_MAN_VAL] ? MSR_MANUAL_MASTER : MSR_MANUAL_SLAVE;
    end else begin
      classify = p1[MSR_CTRL_MULTI] ? MSR_MULTIPORT : MSR_SINGLEPORT;
    end
  endfunction : classify

  assign localType  = classify(ctrl_reg);
  assign remoteType = classify(remP1_reg);
  assign seedLimit  = seedCnt_reg >= MSR_MAX_SEEDS;

  // Resolution table; manual ends take precedence over port type
  always_comb begin
    if (localType == remoteType
        && (localType == MSR_MANUAL_MASTER || localType == MSR_MANUAL_SLAVE)) begin
      outcome = MSR_RES_FAULT;
    end else if (localType == MSR_MANUAL_MASTER) begin
      outcome = MSR_RES_MASTER;
    end else if (localType == MSR_MANUAL_SLAVE) begin
      outcome = MSR_RES_SLAVE;
    end else if (remoteType == MSR_MANUAL_MASTER) begin
      outcome = MSR_RES_SLAVE;
    end else if (remoteType == MSR_MANUAL_SLAVE) begin
      outcome = MSR_RES_MASTER;
    end else if (localType != remoteType) begin
      outcome = (localType == MSR_MULTIPORT) ? MSR_RES_MASTER : MSR_RES_SLAVE;
    end else if (seed_reg > remSeed_reg) begin
      outcome = MSR_RES_MASTER;
    end else if (seed_reg < remSeed_reg) begin
      outcome = MSR_RES_SLAVE;
    end else begin
      outcome = MSR_RES_TIE;
    end
  end

  // Sequencer: first seed at start-up, then wait, then one evaluation
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= ST_RESEED;
    end else if (clkEn) begin
      case (state_reg)
        ST_RESEED: begin
          if (seedIf.valid) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // Entry to link-good check triggers a single evaluation
          if (agEnter) begin
            state_reg <= ST_RESOLVE;
          end
        end
        ST_RESOLVE: begin
          // Tie, or seed-limit fault, needs a fresh seed for the retry
          if (hcd_reg && (outcome == MSR_RES_TIE
                          || (outcome == MSR_RES_FAULT && seedLimit))) begin
            state_reg <= ST_RESEED;
          end else if (hcd_reg && outcome == MSR_RES_TIE) begin
            state_reg <= ST_RESEED;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Partner data captured at the evaluation instant
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      remP1_reg   <= MSR_CTRL_RST;
      remSeed_reg <= MSR_SEED_RST;
      hcd_reg     <= 1'b0;
    end else if (clkEn && state_reg == ST_IDLE && agEnter) begin
      remP1_reg   <= remotePage1;
      remSeed_reg <= remoteSeed;
      hcd_reg     <= hcdIsGigT;
    end
  end

  assign seedIf.req = (state_reg == ST_RESEED);

  // Seed store and attempt counter
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seed_reg    <= MSR_SEED_RST;
      seedCnt_reg <= 4'h0;
    end else if (clkEn) begin
      if (state_reg == ST_RESEED && seedIf.valid) begin
        seed_reg    <= seedIf.seed;
        seedCnt_reg <= seedCnt_reg + 4'h1;
      end else if (state_reg == ST_RESOLVE && hcd_reg
                   && (outcome != MSR_RES_TIE || seedLimit)) begin
        seedCnt_reg <= 4'h0;
      end
    end
  end

  // Role and fault status; role held until the next resolution
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      master_reg   <= 1'b0;
      fault_reg    <= 1'b0;
      resolved_reg <= 1'b0;
    end else if (clkEn && state_reg == ST_RESOLVE && hcd_reg) begin
      if (outcome == MSR_RES_MASTER || outcome == MSR_RES_SLAVE) begin
        master_reg   <= (outcome == MSR_RES_MASTER);
        fault_reg    <= 1'b0;
        resolved_reg <= 1'b1;
      end else if (outcome == MSR_RES_FAULT || seedLimit) begin
        fault_reg    <= 1'b1;
      end
    end
  end

  // One-cycle pulses toward auto-negotiation and PMA
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      linkFail_reg <= 1'b0;
      done_reg     <= 1'b0;
      ind_reg      <= 1'b0;
    end else if (clkEn) begin
      linkFail_reg <= 1'b0;
      done_reg     <= 1'b0;
      ind_reg      <= 1'b0;
      if (state_reg == ST_RESOLVE) begin
        if (!hcd_reg) begin
          done_reg <= 1'b1;
        end else if (outcome == MSR_RES_MASTER || outcome == MSR_RES_SLAVE) begin
          done_reg <= 1'b1;
          ind_reg  <= 1'b1;
        end else if (outcome == MSR_RES_FAULT || seedLimit) begin
          done_reg     <= 1'b1;
          linkFail_reg <= 1'b1;
        end else begin
          linkFail_reg <= 1'b1;
        end
      end
    end
  end

  // Events raised by the resolution step
  always_comb begin
    events = 3'h0;
    if (clkEn && state_reg == ST_RESOLVE && hcd_reg) begin
      events[MSR_EV_OK]    = (outcome == MSR_RES_MASTER || outcome == MSR_RES_SLAVE);
      events[MSR_EV_FAULT] = (outcome == MSR_RES_FAULT)
                             || (outcome == MSR_RES_TIE && seedLimit);
      events[MSR_EV_TIE]   = (outcome == MSR_RES_TIE) && !seedLimit;
    end
  end

  // Bus handshake: one wait cycle, then the access completes
  assign busAcc = (avsRead || avsWrite) && !wait_reg;

  // Wait request is high unless the access is in its final cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wait_reg <= 1'b1;
    end else if (clkEn) begin
      wait_reg <= !((avsRead || avsWrite) && wait_reg);
    end
  end

  // Control register, low byte lane only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_reg <= MSR_CTRL_RST;
    end else if (clkEn && busAcc && avsWrite && avsByteEnable[0]
                 && avsAddress == MSR_OFS_CTRL) begin
      ctrl_reg <= avsWriteData[2:0];
    end
  end

  // Sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irqSt_reg <= MSR_IRQ_RST;
      irqEn_reg <= MSR_IRQ_RST;
      irq_reg   <= 1'b0;
    end else if (clkEn) begin
      if (busAcc && avsWrite && avsByteEnable[0] && avsAddress == MSR_OFS_IRQ_CLR) begin
        irqSt_reg <= (irqSt_reg & ~avsWriteData[2:0]) | events;
      end else begin
        irqSt_reg <= irqSt_reg | events;
      end
      if (busAcc && avsWrite && avsByteEnable[0] && avsAddress == MSR_OFS_IRQ_EN) begin
        irqEn_reg <= avsWriteData[2:0];
      end
      irq_reg <= |(irqSt_reg & irqEn_reg);
    end
  end

  // Read data loaded in the wait cycle; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_reg <= 32'h0000_0000;
    end else if (clkEn && avsRead && wait_reg) begin
      rdata_reg <= 32'h0000_0000;
      if (avsAddress == MSR_OFS_CTRL) begin
        rdata_reg[2:0] <= ctrl_reg;
      end else if (avsAddress == MSR_OFS_STATUS) begin
        rdata_reg[MSR_ST_FAULT]    <= fault_reg;
        rdata_reg[MSR_ST_MASTER]   <= master_reg;
        rdata_reg[MSR_ST_RESOLVED] <= resolved_reg;
        rdata_reg[3:0]             <= seedCnt_reg;
      end else if (avsAddress == MSR_OFS_SEED) begin
        rdata_reg[10:0] <= seed_reg;
      end else if (avsAddress == MSR_OFS_PARTNER) begin
        rdata_reg[10:0]                  <= remSeed_reg;
        rdata_reg[MSR_PARTNER_P1 +: 3]   <= remP1_reg;
      end else if (avsAddress == MSR_OFS_IRQ_ST) begin
        rdata_reg[2:0] <= irqSt_reg;
      end else if (avsAddress == MSR_OFS_IRQ_EN) begin
        rdata_reg[2:0] <= irqEn_reg;
      end
    end
  end

  // Outputs straight from flip-flops
  assign avsReadData    = rdata_reg;
  assign avsWaitRequest = wait_reg;
  assign localPage1     = ctrl_reg;
  assign localSeed      = seed_reg;
  assign linkFail       = linkFail_reg;
  assign resolveDone    = done_reg;
  assign roleMaster     = master_reg;
  assign roleInd        = ind_reg;
  assign cfgFault       = fault_reg;
  assign irq            = irq_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // A frozen cycle holds the state, so only entries on a live edge are checked
  property p_eval_once;
    (state_reg == ST_RESOLVE && $past(clkEn))
      |-> $past(state_reg) == ST_IDLE && $past(agEnter);
  endproperty
  a_eval_once: assert property (p_eval_once) else $error("Evaluation without entry");

  property p_multi;
    (state_reg == ST_RESOLVE && clkEn && hcd_reg && localType == MSR_MULTIPORT
     && remoteType == MSR_SINGLEPORT) |=> roleMaster && roleInd && !cfgFault;
  endproperty
  a_multi: assert property (p_multi) else $error("Multiport end not master");

  property p_manual;
    (state_reg == ST_RESOLVE && clkEn && hcd_reg && localType == MSR_MANUAL_SLAVE
     && remoteType != MSR_MANUAL_SLAVE) |=> !roleMaster && roleInd;
  endproperty
  a_manual: assert property (p_manual) else $error("Manual slave not slave");

  property p_seed;
    (state_reg == ST_RESOLVE && clkEn && hcd_reg && localType == remoteType
     && !ctrl_reg[MSR_CTRL_MAN_EN] && seed_reg != remSeed_reg)
      |=> roleMaster == ($past(seed_reg) > $past(remSeed_reg));
  endproperty
  a_seed: assert property (p_seed) else $error("Seed compare wrong");

  property p_tie;
    (state_reg == ST_RESOLVE && clkEn && hcd_reg && outcome == MSR_RES_TIE && !seedLimit)
      |=> linkFail && !resolveDone && state_reg == ST_RESEED;
  endproperty
  a_tie: assert property (p_tie) else $error("Tie did not force retry");

  property p_count;
    (state_reg == ST_RESEED && seedIf.valid && clkEn)
      |=> seedCnt_reg == $past(seedCnt_reg) + 4'h1;
  endproperty
  a_count: assert property (p_count) else $error("Seed count not advanced");

  property p_ok;
    roleInd |-> !cfgFault && seedCnt_reg == 4'h0 && resolveDone && !linkFail;
  endproperty
  a_ok: assert property (p_ok) else $error("Success left fault or count");

  property p_fault;
    (resolveDone && linkFail) |-> cfgFault && !roleInd;
  endproperty
  a_fault: assert property (p_fault) else $error("Fault completion without fault bit");

  property p_limit;
    (state_reg == ST_RESOLVE && clkEn && hcd_reg && outcome == MSR_RES_TIE && seedLimit)
      |=> cfgFault ##1 seedCnt_reg <= 4'h1;
  endproperty
  a_limit: assert property (p_limit) else $error("Seven seeds without fault");

  property p_hcd;
    (state_reg == ST_RESOLVE && clkEn && !hcd_reg)
      |=> resolveDone && !linkFail && $stable(roleMaster) && $stable(cfgFault);
  endproperty
  a_hcd: assert property (p_hcd) else $error("Arbitration ran without gigabit HCD");

  c_master: cover property (roleInd && roleMaster);
  c_slave:  cover property (roleInd && !roleMaster);
  c_tie:    cover property (linkFail && !resolveDone);
  c_fault:  cover property (resolveDone && linkFail);

endmodule : msr_resolver
`default_nettype wire

// file: verif/msr_partner_model.sv
// Link partner model presenting page bits and seed at link-good check
`timescale 1ns/100ps
`default_nettype none
module msr_partner_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Bench control
  input  wire logic        negGo,
  input  wire logic [2:0]  negPage1,
  input  wire logic [10:0] negSeed,
  input  wire logic        negHcd,
  // Negotiation lines toward the resolver
  output logic             agEnter,
  output logic             hcdIsGigT,
  output logic      [2:0]  remotePage1,
  output logic      [10:0] remoteSeed
);
  // One-cycle page exchange; lines toggle every cycle between exchanges so values one cycle stale never match
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      agEnter     <= 1'b0;
      hcdIsGigT   <= 1'b0;
      remotePage1 <= 3'h0;
      remoteSeed  <= 11'h000;
    end else if (negGo) begin
      agEnter     <= 1'b1;
      hcdIsGigT   <= negHcd;
      remotePage1 <= negPage1;  // {U2,U1,U0} of page 1
      remoteSeed  <= negSeed;   // Seed in page 2, U10 as MSB
    end else begin
      agEnter     <= 1'b0;
      hcdIsGigT   <= ~hcdIsGigT;
      remotePage1 <= ~remotePage1;
      remoteSeed  <= ~remoteSeed;
    end
  end
endmodule : msr_partner_model
`default_nettype wire

// file: verif/msr_resolver_tb.sv
// Self-checking bench for the role resolver
`timescale 1ns/100ps
`default_nettype none
module msr_resolver_tb;
  import msr_pkg::*;
  // Role table: {local ctrl, remote page1, expect 0 slave 1 master 2 fault 3 seed}
  localparam logic [7:0] CASES [18] = '{8'h81, 8'h10, 8'h85, 8'h0c, 8'h65, 8'h2c,
    8'h61, 8'h30, 8'h05, 8'h8c, 8'h71, 8'h20, 8'h26, 8'hc1, 8'h50, 8'h6e, 8'h03, 8'h93};
  logic ref_clk, reset, clkEn, avsRead, avsWrite, avsWaitRequest, irq;
  logic [7:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, rd;
  logic [3:0] avsByteEnable, nDone, nFail, nInd;
  logic agEnter, hcdIsGigT, linkFail, resolveDone, roleMaster, roleInd, cfgFault;
  logic [2:0] remotePage1, localPage1, negPage1;
  logic [10:0] remoteSeed, localSeed, negSeed, lsd;
  logic negGo, negHcd, expM, flt, lastRole;
  logic [7:0] e;
  int errors, checkCount, k;

  // Design and partner
  msr_resolver i_dut (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .agEnter(agEnter), .hcdIsGigT(hcdIsGigT), .remotePage1(remotePage1),
    .remoteSeed(remoteSeed), .localPage1(localPage1), .localSeed(localSeed),
    .linkFail(linkFail), .resolveDone(resolveDone), .roleMaster(roleMaster),
    .roleInd(roleInd), .cfgFault(cfgFault), .irq(irq));
  msr_partner_model i_partner (.ref_clk(ref_clk), .reset(reset), .negGo(negGo),
    .negPage1(negPage1), .negSeed(negSeed), .negHcd(negHcd), .agEnter(agEnter),
    .hcdIsGigT(hcdIsGigT), .remotePage1(remotePage1), .remoteSeed(remoteSeed));

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon-MM access, held until waitrequest is seen low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsByteEnable <= be;
    avsWrite <= wr;
    avsRead <= ~wr;
    // No latency assumed; only the watchdog ends a hung access
    do begin
      @(posedge ref_clk);
    end while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask : bus

  // One exchange, counting outcome pulses over the answer window
  task negotiate(input logic [2:0] p1, input logic [10:0] sd, input logic hcd);
    @(posedge ref_clk);
    negGo <= 1'b1;
    negPage1 <= p1;
    negSeed <= sd;
    negHcd <= hcd;
    @(posedge ref_clk);
    negGo <= 1'b0;
    nDone = 4'h0;
    nFail = 4'h0;
    nInd = 4'h0;
    repeat (6) begin
      @(negedge ref_clk);
      nDone = nDone + resolveDone;
      nFail = nFail + linkFail;
      nInd = nInd + roleInd;
    end
    // Reseed settles before the next exchange
    repeat (6) @(posedge ref_clk);
  endtask : negotiate

  // Verdict
  task tally_and_finish;
    $display("errors %0d checks %0d", errors, checkCount);
    if (errors == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // Watchdog, far beyond the expected run
  initial begin
    #1200000;
    errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    ref_clk = 0; reset = 1; clkEn = 1; avsRead = 0; avsWrite = 0;
    avsAddress = 0; avsWriteData = 0; avsByteEnable = 0;
    negGo = 0; negPage1 = 0; negSeed = 0; negHcd = 0;
    errors = 0; checkCount = 0; lastRole = 0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (8) @(posedge ref_clk);
    bus(0, MSR_OFS_STATUS, 0, 4'hf); chk(rd, 32'h1);
    bus(0, 8'h1c, 0, 4'hf); chk(rd, 32'h0);
    bus(1, MSR_OFS_STATUS, 32'hffffffff, 4'hf);
    bus(0, MSR_OFS_STATUS, 0, 4'hf); chk(rd, 32'h1);
    bus(1, MSR_OFS_CTRL, 32'h7, 4'h0);
    bus(0, MSR_OFS_CTRL, 0, 4'hf); chk(rd, 32'h0);
    bus(1, MSR_OFS_IRQ_EN, 32'h2, 4'hf);
    // Equal seeds, single-port both ends, until the seventh seed faults
    for (k = 1; k <= 7; k++) begin
      negotiate(3'h0, localSeed, 1'b1);
      chk(32'(nFail), 32'h1);
      chk(32'(nDone), 32'(k == 7));
      chk(32'(irq), 32'(k == 7));
      if (k < 7) begin
        bus(0, MSR_OFS_STATUS, 0, 4'hf); chk(32'(rd[3:0]), 32'(k + 1));
      end
    end
    chk(32'(cfgFault), 32'h1);
    bus(0, MSR_OFS_IRQ_ST, 0, 4'hf); chk(rd, 32'h6);
    bus(1, MSR_OFS_IRQ_CLR, 32'h6, 4'hf);
    repeat (3) @(posedge ref_clk);
    chk(32'(irq), 32'h0);
    bus(0, MSR_OFS_IRQ_ST, 0, 4'hf); chk(rd, 32'h0);
    // Every pairing of end types, roles alternating except the two seed cases, which share one seed and so one role
    for (k = 0; k < 18; k++) begin
      e = CASES[k];
      bus(1, MSR_OFS_CTRL, 32'(e[7:5]), 4'hf);
      lsd = localSeed;
      expM = (e[1:0] == 2'h3) ? lsd[10] : e[0];
      flt = (e[1:0] == 2'h2);
      negotiate(e[4:2], lsd ^ 11'h400, 1'b1);
      chk(32'(localPage1), 32'(e[7:5]));
      chk(32'(nDone), 32'h1);
      chk(32'(nFail), 32'(flt));
      chk(32'(nInd), 32'(!flt));
      chk(32'(cfgFault), 32'(flt));
      bus(0, MSR_OFS_STATUS, 0, 4'hf); chk(32'({rd[15], rd[3:0]}), 32'({flt, 4'h0}));
      if (!flt) begin
        chk(32'(roleMaster), 32'(expM));
        chk(32'(rd[14]), 32'(expM));
        lastRole = expM;
      end
    end
    // Non-gigabit common mode passes without arbitration
    bus(1, MSR_OFS_CTRL, 32'h0, 4'hf);
    lsd = localSeed;
    negotiate(3'h5, lsd, 1'b0);
    chk(32'({nDone, nFail, nInd}), 32'h100);
    chk(32'(roleMaster), 32'(lastRole));
    // Partner page and seed are latched even without arbitration
    bus(0, MSR_OFS_PARTNER, 0, 4'hf); chk(rd, 32'h0005_0000 | 32'(lsd));
    chk(32'(localSeed <= MSR_SEED_MAX), 32'h1);
    // Clock enable low: an entry pulse passes unseen
    clkEn <= 1'b0;
    negotiate(3'h0, localSeed, 1'b1);
    clkEn <= 1'b1;
    chk(32'({nDone, nFail, nInd}), 32'h0);
    chk(32'(localSeed), 32'(lsd));
    tally_and_finish();
  end
endmodule : msr_resolver_tb
`default_nettype wire
